// ### hdl/lbfs_supervisor.sv
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "lbfs_consts.svh"
// What this block does
// (RULE_01) Power-up: bus above 105% for 5us after 10us holds gates off until Vcc cycles.
// (RULE_02) Active phases: bus above 109% for 5us stops boost until below 105%.
// (RULE_03) Run: bus above 109% for 625ms powers down, restarts below 105%.
// (RULE_04) Run: lamp peak above threshold for 620us gives latched fault.
// (RULE_05) Run: lamp DC level beyond threshold for 2500ms gives latched fault.
// (RULE_06) Run: capacitive load for 620us gives latched fault.
// (RULE_07) Ignition: run frequency missing after 237ms gives latched fault.
// (RULE_08) Active phases: boost current flag for 200ns ends boost on-time, no fault.
// (RULE_09) Inverter over 0.8V: ignition control after 200ns; preheat/run fault after 500ns.
// (RULE_10) Startup, softstart, ignition, pre-run: inverter over 1.6V for 500ns is fault.
// (RULE_11) Pre-run/run: surge for 500ns powers down, restarts when bus below 109%; in run the 0.8V fault of RULE_09 qualifies no later and latches instead.
// (RULE_12) Latched fault waits 200ms then gives exactly one restart.
// (RULE_13) Failure latch clears on undervoltage lockout or 40s of run.
// (RULE_14) Each condition is classed start-up, no-fault, auto, undervoltage or fault.
// (RULE_15) Startup: bus under 95% after 80ms powers down, waits 200ms, restarts.
// (RULE_16) After power-up, undervoltage for 5us powers down and clears the latch.
// (RULE_17) Flags arrive synchronous; durations are counted in clock cycles.
module lbfs_supervisor #(
	parameter int unsigned CYC_INV_OV    = `LBFS_MS2CYC(`LBFS_T_INV_OV_MS),
	parameter int unsigned CYC_LAMP_PEAK = `LBFS_US2CYC(`LBFS_T_LAMP_PEAK_US),
	parameter int unsigned CYC_LAMP_DC   = `LBFS_MS2CYC(`LBFS_T_LAMP_DC_MS),
	parameter int unsigned CYC_CAP_LOAD  = `LBFS_US2CYC(`LBFS_T_CAP_LOAD_US),
	parameter int unsigned CYC_IGN_TMO   = `LBFS_MS2CYC(`LBFS_T_IGN_TMO_MS),
	parameter int unsigned CYC_START_TMO = `LBFS_MS2CYC(`LBFS_T_START_TMO_MS),
	parameter int unsigned CYC_RESTART   = `LBFS_MS2CYC(`LBFS_T_RESTART_MS),
	parameter int unsigned CYC_LATCH_CLR = `LBFS_S2CYC(`LBFS_T_LATCH_CLR_S)
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 ce,
	input  wire lbfs_pkg::lbfs_phase_t phase,
	input  wire logic                 bus_above_95,
	input  wire logic                 bus_above_105,
	input  wire logic                 bus_above_109,
	input  wire logic                 lamp_wearout_peak_fault,
	input  wire logic                 lamp_wearout_rectify_fault,
	input  wire logic                 cap_load_flag,
	input  wire logic                 run_freq_reached,
	input  wire logic                 boost_current_sense,
	input  wire logic                 inverter_current_sense_08,
	input  wire logic                 inverter_current_sense_16,
	input  wire logic                 uvlo_flag,
	input  wire logic [7:0]           addr,
	input  wire logic [31:0]          wdata,
	input  wire logic                 wr_en,
	input  wire logic                 rd_en,
	output logic [31:0]               rdata,
	output logic                      irq,
	output logic                      power_down,
	output logic                      boost_stop,
	output logic                      boost_ontime_end,
	output logic                      ign_ctrl,
	output logic                      restart,
	output logic                      fail_latch,
	output lbfs_pkg::lbfs_class_t     fault_class
);
	localparam int NF = 16;
	localparam int F_OV105 = 0, F_OV109 = 1, F_OV625 = 2, F_LPK = 3, F_LDC = 4, F_CAP = 5;
	localparam int F_IGNT = 6, F_BCS = 7, F_IGNL = 8, F_INV08 = 9, F_INV16 = 10;
	localparam int F_SURGE = 11, F_STO = 12, F_UV = 13, F_RUN40 = 14, F_PU10 = 15;
	localparam int unsigned LIM [NF] = '{
		`LBFS_US2CYC(`LBFS_T_BUS_OV_US), `LBFS_US2CYC(`LBFS_T_BUS_OV_US), CYC_INV_OV,
		CYC_LAMP_PEAK, CYC_LAMP_DC, CYC_CAP_LOAD, CYC_IGN_TMO,
		`LBFS_NS2CYC(`LBFS_T_BOOST_OC_NS), `LBFS_NS2CYC(`LBFS_T_IGN_LIM_NS),
		`LBFS_NS2CYC(`LBFS_T_INV_OC_NS), `LBFS_NS2CYC(`LBFS_T_INV_OC_NS),
		`LBFS_NS2CYC(`LBFS_T_INV_OC_NS), CYC_START_TMO, `LBFS_US2CYC(`LBFS_T_UVLO_US),
		CYC_LATCH_CLR, `LBFS_US2CYC(`LBFS_T_PU_SETTLE_US)};

	lbfs_pkg::lbfs_state_t st_r, st_nxt;
	logic [NF-1:0]          cond, qual;
	logic [31:0]            cnt_r [NF];
	logic [31:0]            dly_cnt_r;
	logic                   en_r, wait109_r, restart_r, pd_r, bstop_r, bend_r, ign_r, latch_r;
	logic                   guard, act_ph, pre_or_run, f_ev, a_ev, uv_ev, lock_ev;
	logic [`LBFS_IRQ_W-1:0] ev, stat_r, irq_en_r;
	logic [31:0]            rdata_r;
	lbfs_pkg::lbfs_class_t  class_r;

	assign guard = (st_r == lbfs_pkg::ST_ACTIVE) && en_r;
	assign act_ph = (phase != lbfs_pkg::PH_OFF) && (phase != lbfs_pkg::PH_PWRUP);
	assign pre_or_run = (phase == lbfs_pkg::PH_PRERUN) || (phase == lbfs_pkg::PH_RUN);

	// Qualification per monitored condition and phase
	always_comb begin
		cond[F_PU10]  = phase == lbfs_pkg::PH_PWRUP;
		cond[F_OV105] = guard && cond[F_PU10] && (cnt_r[F_PU10] == LIM[F_PU10])
			&& bus_above_105; // RULE_01
		cond[F_OV109] = guard && act_ph && bus_above_109; // RULE_02
		cond[F_OV625] = guard && phase == lbfs_pkg::PH_RUN && bus_above_109; // RULE_03
		cond[F_LPK]   = guard && phase == lbfs_pkg::PH_RUN && lamp_wearout_peak_fault; // RULE_04
		cond[F_LDC]   = guard && phase == lbfs_pkg::PH_RUN && lamp_wearout_rectify_fault; // RULE_05
		cond[F_CAP]   = guard && phase == lbfs_pkg::PH_RUN && cap_load_flag; // RULE_06
		cond[F_IGNT]  = guard && phase == lbfs_pkg::PH_IGNITION && !run_freq_reached; // RULE_07
		cond[F_BCS]   = guard && act_ph && boost_current_sense; // RULE_08
		cond[F_IGNL]  = guard && phase == lbfs_pkg::PH_IGNITION
			&& inverter_current_sense_08; // RULE_09
		cond[F_INV08] = guard && (phase == lbfs_pkg::PH_PREHEAT || phase == lbfs_pkg::PH_RUN)
			&& inverter_current_sense_08; // RULE_09
		cond[F_INV16] = guard && act_ph && phase != lbfs_pkg::PH_PREHEAT
			&& phase != lbfs_pkg::PH_RUN && inverter_current_sense_16; // RULE_10
		cond[F_SURGE] = guard && pre_or_run && inverter_current_sense_08
			&& bus_above_109; // RULE_11
		cond[F_STO]   = guard && phase == lbfs_pkg::PH_STARTUP && !bus_above_95; // RULE_15
		cond[F_UV]    = phase != lbfs_pkg::PH_OFF && uvlo_flag; // RULE_16
		cond[F_RUN40] = guard && phase == lbfs_pkg::PH_RUN; // RULE_13
	end

	// Duration counters: a flag must stay asserted for the full count
	for (genvar i = 0; i < NF; i++) begin : g_filt
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				cnt_r[i] <= 32'h0;
			end else if (ce) begin
				if (!cond[i]) begin
					cnt_r[i] <= 32'h0;
				end else if (cnt_r[i] != LIM[i]) begin
					cnt_r[i] <= cnt_r[i] + 32'h1; // RULE_17
				end
			end
		end
		assign qual[i] = ce && cond[i] && (cnt_r[i] == LIM[i]);
	end

	assign f_ev = qual[F_LPK] | qual[F_LDC] | qual[F_CAP] | qual[F_IGNT]
		| qual[F_INV08] | qual[F_INV16];
	assign a_ev = qual[F_OV625] | qual[F_SURGE] | qual[F_STO];
	assign uv_ev = qual[F_UV];
	assign lock_ev = guard && !uv_ev && f_ev && latch_r;

	// Power-down sequencing
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			lbfs_pkg::ST_ACTIVE: begin
				if (f_ev) begin
					st_nxt = latch_r ? lbfs_pkg::ST_LOCK : lbfs_pkg::ST_DELAY; // RULE_12
				end else if (qual[F_STO]) begin
					st_nxt = lbfs_pkg::ST_DELAY; // RULE_15
				end else if (qual[F_SURGE] || qual[F_OV625]) begin
					st_nxt = lbfs_pkg::ST_WAITBUS; // RULE_03 RULE_11
				end else if (qual[F_OV105]) begin
					st_nxt = lbfs_pkg::ST_HOLD; // RULE_01
				end
			end
			lbfs_pkg::ST_HOLD: begin
				if (uvlo_flag) begin
					st_nxt = lbfs_pkg::ST_UV; // RULE_01
				end
			end
			lbfs_pkg::ST_WAITBUS: begin
				if (wait109_r ? !bus_above_109 : !bus_above_105) begin
					st_nxt = lbfs_pkg::ST_ACTIVE;
				end
			end
			lbfs_pkg::ST_DELAY: begin
				if (dly_cnt_r == CYC_RESTART - 1) begin
					st_nxt = lbfs_pkg::ST_ACTIVE; // RULE_12
				end
			end
			lbfs_pkg::ST_LOCK: begin
				if (!latch_r) begin
					st_nxt = lbfs_pkg::ST_ACTIVE;
				end
			end
			lbfs_pkg::ST_UV: begin
				if (!uvlo_flag) begin
					st_nxt = lbfs_pkg::ST_ACTIVE;
				end
			end
		endcase
		if (uv_ev) begin
			st_nxt = lbfs_pkg::ST_UV; // RULE_16
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= lbfs_pkg::ST_ACTIVE;
			pd_r <= 1'b0;
			restart_r <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
			pd_r <= st_nxt != lbfs_pkg::ST_ACTIVE;
			restart_r <= st_r != lbfs_pkg::ST_ACTIVE && st_nxt == lbfs_pkg::ST_ACTIVE;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dly_cnt_r <= 32'h0;
		end else if (ce) begin
			dly_cnt_r <= (st_r == lbfs_pkg::ST_DELAY) ? dly_cnt_r + 32'h1 : 32'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait109_r <= 1'b0;
		end else if (ce && st_r == lbfs_pkg::ST_ACTIVE) begin
			wait109_r <= qual[F_SURGE]; // RULE_11
		end
	end

	// Failure latch: a new fault wins over the 40s run clear in the same cycle; undervoltage wins over a fault
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_r <= 1'b0;
		end else if (ce) begin
			if (guard && f_ev && !uv_ev) begin
				latch_r <= 1'b1;
			end else if (uv_ev || qual[F_RUN40]) begin
				latch_r <= 1'b0; // RULE_13
			end
		end
	end

	// No-fault regulation of the boost stage and ignition control
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bstop_r <= 1'b0;
			bend_r <= 1'b0;
			ign_r <= 1'b0;
		end else if (ce) begin
			if (qual[F_OV109]) begin
				bstop_r <= 1'b1; // RULE_02
			end else if (!bus_above_105 || !act_ph || !guard) begin
				bstop_r <= 1'b0;
			end
			bend_r <= qual[F_BCS]; // RULE_08
			ign_r <= qual[F_IGNL]; // RULE_09
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			class_r <= lbfs_pkg::CL_NONE;
		end else if (ce) begin
			if (uv_ev || qual[F_OV105]) begin
				class_r <= lbfs_pkg::CL_START; // RULE_14
			end else if (f_ev) begin
				class_r <= lbfs_pkg::CL_FAULT;
			end else if (qual[F_SURGE] || qual[F_STO]) begin
				class_r <= lbfs_pkg::CL_AUTO;
			end else if (qual[F_OV625]) begin
				class_r <= lbfs_pkg::CL_UNDERV;
			end else if (qual[F_OV109] || qual[F_BCS] || qual[F_IGNL]) begin
				class_r <= lbfs_pkg::CL_NOFAULT;
			end
		end
	end

	// Sticky events; set wins over a clear in the same cycle
	assign ev = {lock_ev, f_ev, uv_ev, a_ev, qual[F_OV109], qual[F_OV105]};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= '0;
		end else if (ce) begin
			stat_r <= (wr_en && addr == `LBFS_ADDR_IRQ_CLR)
				? ((stat_r & ~wdata[`LBFS_IRQ_W-1:0]) | ev) : (stat_r | ev);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_r <= `LBFS_CTRL_RESET;
			irq_en_r <= `LBFS_IRQ_EN_RESET;
		end else if (ce && wr_en) begin
			if (addr == `LBFS_ADDR_CTRL) begin
				en_r <= wdata[`LBFS_CTRL_EN_BIT];
			end
			if (addr == `LBFS_ADDR_IRQ_EN) begin
				irq_en_r <= wdata[`LBFS_IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h0;
		end else if (ce) begin
			rdata_r <= 32'h0;
			if (rd_en) begin
				unique case (addr)
					`LBFS_ADDR_CTRL:     rdata_r <= {31'h0, en_r};
					`LBFS_ADDR_STATUS:   rdata_r <= {21'h0, class_r, bstop_r, latch_r, st_r};
					`LBFS_ADDR_IRQ_STAT: rdata_r <= {26'h0, stat_r};
					`LBFS_ADDR_IRQ_EN:   rdata_r <= {26'h0, irq_en_r};
					default:             rdata_r <= 32'h0;
				endcase
			end
		end
	end

	assign rdata = rdata_r;
	assign irq = |(stat_r & irq_en_r);
	assign power_down = pd_r;
	assign boost_stop = bstop_r;
	assign boost_ontime_end = bend_r;
	assign ign_ctrl = ign_r;
	assign restart = restart_r;
	assign fail_latch = latch_r;
	assign fault_class = class_r;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || !ce);

	boost_ov_stop_a: assert property (qual[F_OV109] |=> boost_stop) // RULE_02
		else $error("boost not stopped on overvoltage");
	ontime_end_a: assert property (qual[F_BCS] |=> boost_ontime_end) // RULE_08
		else $error("boost on-time not ended");
	ign_ctrl_a: assert property (qual[F_IGNL] |=> ign_ctrl) // RULE_09
		else $error("ignition control not active");
	fault_latch_a: assert property (guard && f_ev && !uv_ev && !latch_r |=>
		power_down && fail_latch && st_r == lbfs_pkg::ST_DELAY) // RULE_04
		else $error("fault did not latch and power down");
	single_restart_a: assert property (lock_ev |=>
		st_r == lbfs_pkg::ST_LOCK ##1 power_down) // RULE_12
		else $error("second fault allowed a restart");
	delay_hold_a: assert property (st_r == lbfs_pkg::ST_DELAY
		&& dly_cnt_r < CYC_RESTART - 1 && !uv_ev |=> !restart && power_down) // RULE_12
		else $error("restart before delay elapsed");
	uv_clear_a: assert property (uv_ev |=> !fail_latch && power_down) // RULE_16
		else $error("undervoltage did not clear latch");
	inv16_dur_a: assert property (qual[F_INV16] |-> $past(cond[F_INV16], 20)) // RULE_10
		else $error("overcurrent qualified too early");
	surge_wait_a: assert property (guard && qual[F_SURGE] && !uv_ev && !f_ev
		&& !qual[F_STO] |=> st_r == lbfs_pkg::ST_WAITBUS && wait109_r) // RULE_11
		else $error("surge did not power down");
	hold_keep_a: assert property (st_r == lbfs_pkg::ST_HOLD && !uvlo_flag && !uv_ev
		|=> st_r == lbfs_pkg::ST_HOLD) // RULE_01
		else $error("hold released without supply cycle");

	fault_restart_c: cover property (st_r == lbfs_pkg::ST_DELAY ##1 restart);
	lock_c: cover property (lock_ev);
	surge_c: cover property (st_r == lbfs_pkg::ST_WAITBUS ##[1:50] restart);
	irq_c: cover property ($rose(irq));
endmodule

// ### shared/lbfs_consts.svh
`ifndef LBFS_CONSTS_SVH
`define LBFS_CONSTS_SVH
// Clock rate and time to cycle conversion (least times round up)
`define LBFS_CLK_KHZ 40000
`define LBFS_NS2CYC(t) ((((t) * `LBFS_CLK_KHZ) + 999999) / 1000000)
`define LBFS_US2CYC(t) ((((t) * `LBFS_CLK_KHZ) + 999) / 1000)
`define LBFS_MS2CYC(t) ((t) * `LBFS_CLK_KHZ)
`define LBFS_S2CYC(t) ((t) * `LBFS_CLK_KHZ * 1000)
// Minimum fault durations, as printed
`define LBFS_T_PU_SETTLE_US 10
`define LBFS_T_BUS_OV_US 5
`define LBFS_T_UVLO_US 5
`define LBFS_T_INV_OV_MS 625
`define LBFS_T_LAMP_PEAK_US 620
`define LBFS_T_LAMP_DC_MS 2500
`define LBFS_T_CAP_LOAD_US 620
`define LBFS_T_IGN_TMO_MS 237
`define LBFS_T_BOOST_OC_NS 200
`define LBFS_T_IGN_LIM_NS 200
`define LBFS_T_INV_OC_NS 500
`define LBFS_T_START_TMO_MS 80
`define LBFS_T_RESTART_MS 200
`define LBFS_T_LATCH_CLR_S 40
// Register offsets
`define LBFS_ADDR_CTRL 8'h00
`define LBFS_ADDR_STATUS 8'h04
`define LBFS_ADDR_IRQ_STAT 8'h08
`define LBFS_ADDR_IRQ_CLR 8'h0C
`define LBFS_ADDR_IRQ_EN 8'h10
// Field positions and reset values
`define LBFS_CTRL_EN_BIT 0
`define LBFS_CTRL_RESET 1'h1
`define LBFS_IRQ_W 6
`define LBFS_IRQ_EN_RESET 6'h00
`endif

// ### shared/lbfs_pkg.sv
package lbfs_pkg;
	typedef enum logic [2:0] {
		PH_OFF = 3'h0, PH_PWRUP = 3'h1, PH_STARTUP = 3'h2, PH_SOFTSTART = 3'h3,
		PH_PREHEAT = 3'h4, PH_IGNITION = 3'h5, PH_PRERUN = 3'h6, PH_RUN = 3'h7
	} lbfs_phase_t;
	typedef enum logic [2:0] {
		CL_NONE = 3'h0, CL_START = 3'h1, CL_NOFAULT = 3'h2, CL_AUTO = 3'h3,
		CL_UNDERV = 3'h4, CL_FAULT = 3'h5
	} lbfs_class_t;
	typedef enum logic [5:0] {
		ST_ACTIVE = 6'h01, ST_HOLD = 6'h02, ST_WAITBUS = 6'h04,
		ST_DELAY = 6'h08, ST_LOCK = 6'h10, ST_UV = 6'h20
	} lbfs_state_t;
endpackage

// ### tb/lbfs_front_model.sv
`timescale 1ns/1ps
// Comparator bank ahead of the supervisor; levels in percent of rated bus and millivolts
module lbfs_front_model (
	input  var int     bus_pct,
	input  var int     inv_mv,
	input  var int     boost_mv,
	input  var int     vcc_mv,
	input  wire [3:0]  misc,
	input  wire logic  power_down,
	output logic       bus_above_95,
	output logic       bus_above_105,
	output logic       bus_above_109,
	output logic       lamp_wearout_peak_fault,
	output logic       lamp_wearout_rectify_fault,
	output logic       cap_load_flag,
	output logic       run_freq_reached,
	output logic       boost_current_sense,
	output logic       inverter_current_sense_08,
	output logic       inverter_current_sense_16,
	output logic       uvlo_flag
);
	// Levels change only just after a clock edge, so every flag is synchronous
	assign bus_above_95 = bus_pct > 95;
	assign bus_above_105 = bus_pct > 105;
	assign bus_above_109 = bus_pct > 109;
	// Gates off: no lamp or inverter current left to sense
	assign lamp_wearout_peak_fault = !power_down && misc[0];
	assign lamp_wearout_rectify_fault = !power_down && misc[1];
	assign cap_load_flag = !power_down && misc[2];
	assign run_freq_reached = !misc[3];
	assign boost_current_sense = boost_mv > 1000;
	assign inverter_current_sense_08 = !power_down && inv_mv > 800;
	assign inverter_current_sense_16 = !power_down && inv_mv > 1600;
	assign uvlo_flag = vcc_mv < 10600;
endmodule

// ### tb/lbfs_supervisor_tb.sv
`timescale 1ns/1ps
`include "lbfs_consts.svh"
module lbfs_supervisor_tb;
	localparam int R = 150;
	localparam int LC = 600;
	typedef struct {
		lbfs_pkg::lbfs_phase_t ph;
		int                    bus;
		int                    inv;
		int                    bst;
		logic [3:0]            m;
		int                    n;
		int                    sel;
		lbfs_pkg::lbfs_class_t cls;
	} lbfs_row_t;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  ce = 1'b1;
	lbfs_pkg::lbfs_phase_t phase = lbfs_pkg::PH_OFF;
	int                    bus_pct = 100;
	int                    inv_mv = 0;
	int                    boost_mv = 0;
	int                    vcc_mv = 12000;
	logic [3:0]            misc = 4'h0;
	logic [7:0]            addr = 8'h00;
	logic [31:0]           wdata = 32'h0;
	logic                  wr_en = 1'b0;
	logic                  rd_en = 1'b0;
	logic [31:0]           rdata, d;
	logic                  irq, power_down, boost_stop, boost_ontime_end, ign_ctrl, restart;
	logic                  fail_latch;
	lbfs_pkg::lbfs_class_t fault_class;
	logic                  bus_above_95, bus_above_105, bus_above_109, lamp_wearout_peak_fault;
	logic                  lamp_wearout_rectify_fault, cap_load_flag, run_freq_reached, uvlo_flag;
	logic                  boost_current_sense, inverter_current_sense_08, inverter_current_sense_16;
	logic [4:0]            outs;
	int                    err_count = 0;
	int                    checked = 0;
	int                    cyc;
	time                   t0;
	lbfs_row_t             rows[15] = '{
		'{lbfs_pkg::PH_RUN, 100, 0, 0, 4'h1, 60, 0, lbfs_pkg::CL_FAULT},
		'{lbfs_pkg::PH_RUN, 100, 0, 0, 4'h2, 120, 0, lbfs_pkg::CL_FAULT},
		'{lbfs_pkg::PH_RUN, 100, 0, 0, 4'h4, 70, 0, lbfs_pkg::CL_FAULT},
		'{lbfs_pkg::PH_IGNITION, 100, 0, 0, 4'h8, 90, 0, lbfs_pkg::CL_FAULT},
		'{lbfs_pkg::PH_PREHEAT, 100, 1000, 0, 4'h0, 20, 0, lbfs_pkg::CL_FAULT},
		'{lbfs_pkg::PH_IGNITION, 100, 1000, 0, 4'h0, 8, 3, lbfs_pkg::CL_NONE},
		'{lbfs_pkg::PH_STARTUP, 100, 2000, 0, 4'h0, 20, 0, lbfs_pkg::CL_FAULT},
		'{lbfs_pkg::PH_SOFTSTART, 100, 2000, 0, 4'h0, 20, 0, lbfs_pkg::CL_FAULT},
		'{lbfs_pkg::PH_IGNITION, 100, 2000, 0, 4'h0, 20, 0, lbfs_pkg::CL_FAULT},
		'{lbfs_pkg::PH_PRERUN, 100, 2000, 0, 4'h0, 20, 0, lbfs_pkg::CL_FAULT},
		'{lbfs_pkg::PH_PRERUN, 110, 1000, 0, 4'h0, 20, 0, lbfs_pkg::CL_AUTO},
		'{lbfs_pkg::PH_RUN, 110, 0, 0, 4'h0, 100, 0, lbfs_pkg::CL_UNDERV},
		'{lbfs_pkg::PH_STARTUP, 90, 0, 0, 4'h0, 300, 0, lbfs_pkg::CL_AUTO},
		'{lbfs_pkg::PH_SOFTSTART, 110, 0, 0, 4'h0, 200, 1, lbfs_pkg::CL_NONE},
		'{lbfs_pkg::PH_STARTUP, 100, 0, 1100, 4'h0, 8, 2, lbfs_pkg::CL_NONE}
	};

	assign outs = {restart, ign_ctrl, boost_ontime_end, boost_stop, power_down};
	always #12.5 clk = ~clk;

	lbfs_front_model front (.bus_pct, .inv_mv, .boost_mv, .vcc_mv, .misc, .power_down,
		.bus_above_95, .bus_above_105, .bus_above_109, .lamp_wearout_peak_fault,
		.lamp_wearout_rectify_fault, .cap_load_flag, .run_freq_reached, .boost_current_sense,
		.inverter_current_sense_08, .inverter_current_sense_16, .uvlo_flag);

	lbfs_supervisor #(.CYC_INV_OV(100), .CYC_LAMP_PEAK(60), .CYC_LAMP_DC(120), .CYC_CAP_LOAD(70),
		.CYC_IGN_TMO(90), .CYC_START_TMO(300), .CYC_RESTART(R), .CYC_LATCH_CLR(LC)) dut (
		.clk, .rst_n, .ce, .phase, .bus_above_95, .bus_above_105, .bus_above_109,
		.lamp_wearout_peak_fault, .lamp_wearout_rectify_fault, .cap_load_flag, .run_freq_reached,
		.boost_current_sense, .inverter_current_sense_08, .inverter_current_sense_16, .uvlo_flag,
		.addr, .wdata, .wr_en, .rd_en, .rdata, .irq, .power_down, .boost_stop,
		.boost_ontime_end, .ign_ctrl, .restart, .fail_latch, .fault_class);

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic set_lv(input lbfs_pkg::lbfs_phase_t p, input int b, input int i, input int s,
		input logic [3:0] m);
		@(posedge clk);
		phase <= p;
		bus_pct <= b;
		inv_mv <= i;
		boost_mv <= s;
		misc <= m;
	endtask

	task automatic reset_dut();
		@(posedge clk);
		rst_n <= 1'b0;
		vcc_mv <= 12000;
		set_lv(lbfs_pkg::PH_OFF, 100, 0, 0, 4'h0);
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	// Bounded wait for one of the watched outputs to be high
	task automatic wait_out(input int s, input int lim, output int c);
		c = 0;
		while (outs[s] !== 1'b1 && c < lim) begin
			@(posedge clk);
			#1 c++;
		end
	endtask

	task automatic give_verdict();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#500000;
		err_count++;
		give_verdict();
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("reset_outs", 32'h0, {irq, outs, fail_latch});
		chk("reset_class", lbfs_pkg::CL_NONE, fault_class);
		rd(`LBFS_ADDR_CTRL, d);
		chk("ctrl", 32'h1, d);
		rd(`LBFS_ADDR_IRQ_EN, d);
		chk("irq_en", 32'h0, d);
		rd(8'h20, d);
		chk("unmapped", 32'h0, d);
		foreach (rows[i]) begin
			reset_dut();
			set_lv(rows[i].ph, rows[i].bus, rows[i].inv, rows[i].bst, rows[i].m);
			repeat (rows[i].n) @(posedge clk);
			#1 chk("early", 1'b0, outs[rows[i].sel]);
			@(posedge clk);
			#1 chk("action", 1'b1, outs[rows[i].sel]);
			if (rows[i].sel == 0) begin
				chk("class", rows[i].cls, fault_class);
				chk("latch", rows[i].cls == lbfs_pkg::CL_FAULT, fail_latch);
			end
		end
		// Latched fault, masked and cleared interrupt, single restart, lockout, undervoltage
		reset_dut();
		set_lv(lbfs_pkg::PH_STARTUP, 100, 2000, 0, 4'h0);
		wait_out(0, 40, cyc);
		t0 = $time;
		rd(`LBFS_ADDR_IRQ_STAT, d);
		chk("stat_fault", 1'b1, d[4]);
		chk("irq_masked", 1'b0, irq);
		wr(`LBFS_ADDR_IRQ_EN, 32'h10);
		#1 chk("irq_on", 1'b1, irq);
		wr(`LBFS_ADDR_IRQ_CLR, 32'h10);
		#1 chk("irq_clr", 1'b0, irq);
		wait_out(4, R + 10, cyc);
		cyc = ($time - t0) / 25;
		chk("restart_gap", 1'b1, cyc >= R && cyc <= R + 3);
		chk("latch_kept", 1'b1, fail_latch);
		wait_out(0, 40, cyc);
		chk("refault", 1'b1, power_down);
		wait_out(4, 2 * R, cyc);
		chk("no_restart", 1'b0, restart);
		rd(`LBFS_ADDR_IRQ_STAT, d);
		chk("stat_lock", 1'b1, d[5]);
		@(posedge clk);
		vcc_mv <= 10000;
		repeat (210) @(posedge clk);
		#1 chk("uv_latch", 1'b0, fail_latch);
		chk("uv_class", lbfs_pkg::CL_START, fault_class);
		@(posedge clk);
		vcc_mv <= 12000;
		wait_out(4, 50, cyc);
		chk("uv_restart", 1'b1, restart);
		// Failure latch cleared by a long stretch of run
		reset_dut();
		set_lv(lbfs_pkg::PH_RUN, 100, 0, 0, 4'h1);
		wait_out(0, 80, cyc);
		set_lv(lbfs_pkg::PH_RUN, 100, 0, 0, 4'h0);
		wait_out(4, R + 10, cyc);
		repeat (LC - 10) @(posedge clk);
		#1 chk("latch_hold", 1'b1, fail_latch);
		repeat (20) @(posedge clk);
		#1 chk("latch_clr", 1'b0, fail_latch);
		// Power-up overvoltage ignored during settling, then holds the gates off
		reset_dut();
		set_lv(lbfs_pkg::PH_PWRUP, 106, 0, 0, 4'h0);
		repeat (390) @(posedge clk);
		#1 chk("pu_early", 1'b0, power_down);
		wait_out(0, 220, cyc);
		chk("pu_hold", 1'b1, power_down);
		set_lv(lbfs_pkg::PH_PWRUP, 100, 0, 0, 4'h0);
		repeat (50) @(posedge clk);
		#1 chk("pu_stay", 1'b1, power_down);
		rd(`LBFS_ADDR_STATUS, d);
		chk("status_hold", 32'h102, d);
		// Surge waits for the bus below 109%, long overvoltage for below 105%
		reset_dut();
		set_lv(lbfs_pkg::PH_PRERUN, 110, 1000, 0, 4'h0);
		wait_out(0, 40, cyc);
		set_lv(lbfs_pkg::PH_PRERUN, 107, 1000, 0, 4'h0);
		wait_out(4, 10, cyc);
		chk("surge_restart", 1'b1, restart);
		reset_dut();
		set_lv(lbfs_pkg::PH_RUN, 110, 0, 0, 4'h0);
		wait_out(0, 120, cyc);
		set_lv(lbfs_pkg::PH_RUN, 107, 0, 0, 4'h0);
		wait_out(4, 20, cyc);
		chk("ov_wait", 1'b0, restart);
		set_lv(lbfs_pkg::PH_RUN, 100, 0, 0, 4'h0);
		wait_out(4, 10, cyc);
		chk("ov_restart", 1'b1, restart);
		// Monitoring off while disabled; clock enable low freezes the duration count
		reset_dut();
		wr(`LBFS_ADDR_CTRL, 32'h0);
		set_lv(lbfs_pkg::PH_RUN, 100, 0, 0, 4'h1);
		repeat (100) @(posedge clk);
		#1 chk("en_off", 1'b0, power_down);
		wr(`LBFS_ADDR_CTRL, 32'h1);
		repeat (30) @(posedge clk);
		ce <= 1'b0;
		repeat (100) @(posedge clk);
		ce <= 1'b1;
		#1 chk("ce_freeze", 1'b0, power_down);
		wait_out(0, 40, cyc);
		chk("ce_resume", 1'b1, cyc == 60 - 30 + 1);
		chk("ce_fault", 1'b1, power_down);
		give_verdict();
	end
endmodule
